// ==== rtl/epr_pkg.sv ====
// Constants, field layouts and reset values of the error and reset state block.
// Assumes one clock, a synchronous active-high cold reset and a soft reset input.
//
// Operation
// - Parity error address captured into info bits.
// - Extra flag set when data and fetch fail.
// - Restart PC saved on error, resets, NMI.
// - Saved PC is faulting or preceding branch.
// - Read returns PC high bits, select bit zero.
// - Write splits data into PC and select.
// - Error PC fully writable, reset undefined.
// - Debug save word is plain storage.
// - Scratch words at selects two, three, reported.
// - Selects zero and one hold no scratch.
// - Resets set boot, error; clear others.
// - Soft reset flag shows which reset.
// - Resets load kseg zero coherency uncached.
// - Resets clear debug bits, debug mode from boot-debug.
// - Config mirror fields reload from inputs.
// - Resets abort bus, reset interface machines.
// - First fetch goes to boot vector unless boot-debug.
// - Timer match write clears timer interrupt.
package epr_pkg;
	// ****************************************
	// Coprocessor register numbers and selects
	// ****************************************
	localparam logic [4:0] REG_PARITY_INFO  = 5'h1b;  // Parity error info
	localparam logic [4:0] REG_ERROR_PC     = 5'h1e;  // Error return PC
	localparam logic [4:0] REG_SAVE_SCRATCH = 5'h1f;  // Debug save and scratch
	localparam logic [4:0] REG_TIMER_MATCH  = 5'h0b;  // Timer match
	localparam logic [2:0] SEL_DEBUG_SAVE   = 3'h0;   // Debug save select
	localparam logic [2:0] SEL_RESERVED     = 3'h1;   // Reserved debug select
	localparam logic [2:0] SEL_SCRATCH_LO   = 3'h2;   // First scratch select
	localparam logic [2:0] SEL_SCRATCH_HI   = 3'h3;   // Second scratch select
	localparam logic [7:0] SCRATCH_PRESENT  = 8'h0c;  // Selects 2 and 3 populated
	// ****************************************
	// Field layouts
	// ****************************************
	localparam int PI_REF_BIT   = 31;                 // Reference type bit
	localparam int PI_EXTRA_BIT = 30;                 // Extra data error bit
	localparam int PI_ADDR_W    = 30;                 // Address field width
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0]  KSEG0_UNCACHED = 3'h2;    // Binary 010
	localparam logic [31:0] BOOT_VECTOR    = 32'hbfc00000; // Virtual boot fetch
	localparam logic [31:0] BOOT_PHYS      = 32'h1fc00000; // Physical boot fetch
	localparam logic [31:0] ZERO_WORD      = 32'h00000000; // Zero word
	// Bus interface machine states
	typedef enum logic [1:0] {EPR_BUS_IDLE, EPR_BUS_WAIT, EPR_BUS_DONE} epr_bus_state_t;
endpackage : epr_pkg

// ==== rtl/epr_cop_if.sv ====
// Interface carrying coprocessor moves between top and storage module.
// Assumes all members are sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface epr_cop_if;
	logic        wr_save;    // Write debug save word
	logic        wr_scr_lo;  // Write first scratch
	logic        wr_scr_hi;  // Write second scratch
	logic [31:0] wdata;      // Write data
	logic [2:0]  rsel;       // Read select
	logic [31:0] rdata;      // Registered read data
	modport master (output wr_save, wr_scr_lo, wr_scr_hi, wdata, rsel, input rdata);
	modport slave  (input wr_save, wr_scr_lo, wr_scr_hi, wdata, rsel, output rdata);
endinterface : epr_cop_if
`default_nettype wire

// ==== rtl/epr_word_store.sv ====
// Small memory of the debug save and kernel scratch words.
// Assumes writes come from coprocessor moves; read data is registered.
`timescale 1ns/1ps
`default_nettype none
module epr_word_store
	import epr_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic ce,
	epr_cop_if.slave  bus
);
	logic [31:0] save_word;   // Debug save word
	logic [31:0] scr_lo;      // Scratch select 2
	logic [31:0] scr_hi;      // Scratch select 3

	// Plain storage, no reset, no side effects
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (bus.wr_save) save_word <= bus.wdata;
			if (bus.wr_scr_lo) scr_lo <= bus.wdata;
			if (bus.wr_scr_hi) scr_hi <= bus.wdata;
		end
	end

	// Registered read; reserved select reads zero
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			case (bus.rsel)
				SEL_DEBUG_SAVE: bus.rdata <= save_word;
				SEL_SCRATCH_LO: bus.rdata <= scr_lo;
				SEL_SCRATCH_HI: bus.rdata <= scr_hi;
				default:        bus.rdata <= ZERO_WORD;
			endcase
		end
	end
endmodule : epr_word_store
`default_nettype wire

// ==== rtl/epr_fetch_seq.sv ====
// Bus abort and first fetch sequencer after either reset.
// Assumes bus_ack answers a pending fetch request.
`timescale 1ns/1ps
`default_nettype none
module epr_fetch_seq
	import epr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        ce,
	input  wire logic        any_reset,
	input  wire logic        boot_into_debug_option,
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        bus_ack,
	output logic             bus_req,
	output logic [31:0]      bus_addr,
	output logic             boot_pending
);
	epr_bus_state_t state;   // Interface machine state

	// Interface machine, forced idle and aborted on reset
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			state        <= EPR_BUS_IDLE;
			bus_req      <= 1'b0;
			bus_addr     <= BOOT_VECTOR;
			boot_pending <= ~boot_into_debug_option;
		end else if (ce) begin
			case (state)
				EPR_BUS_IDLE: begin
					if (boot_pending) begin
						bus_req  <= 1'b1;
						bus_addr <= BOOT_VECTOR;
						state    <= EPR_BUS_WAIT;
					end else if (fetch_req) begin
						bus_req  <= 1'b1;
						bus_addr <= fetch_addr;
						state    <= EPR_BUS_WAIT;
					end
				end
				EPR_BUS_WAIT: begin
					if (bus_ack) begin
						bus_req      <= 1'b0;
						boot_pending <= 1'b0;
						state        <= EPR_BUS_DONE;
					end
				end
				EPR_BUS_DONE: state <= EPR_BUS_IDLE;
				default:      state <= EPR_BUS_IDLE;
			endcase
		end
	end
endmodule : epr_fetch_seq
`default_nettype wire

// ==== rtl/epr_top.sv ====
// Error PC, parity capture, reset initialisation state of the core.
// Assumes coprocessor moves arrive as one-cycle strobes on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module epr_top
	import epr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        ce,
	input  wire logic        rst,
	input  wire logic        soft_reset_input,
	input  wire logic        boot_into_debug_option,
	input  wire logic [2:0]  static_config_in,
	input  wire logic        parity_error,
	input  wire logic        parity_ref_data,
	input  wire logic        parity_extra_data,
	input  wire logic [29:0] parity_addr,
	input  wire logic        error_exception,
	input  wire logic        nmi_exception,
	input  wire logic [31:0] fault_pc,
	input  wire logic        fault_in_delay_slot,
	input  wire logic [31:0] branch_pc,
	input  wire logic        mtc0,
	input  wire logic        mfc0,
	input  wire logic [4:0]  cop_reg,
	input  wire logic [2:0]  cop_sel,
	input  wire logic [31:0] cop_wdata,
	input  wire logic        timer_irq_set,
	input  wire logic        fetch_req,
	input  wire logic [31:0] fetch_addr,
	input  wire logic        bus_ack,
	output logic [31:0]      cop_rdata,
	output logic             boot_vector_bit,
	output logic             tlb_shutdown_bit,
	output logic             soft_reset_flag,
	output logic             nmi_status_bit,
	output logic             error_level_bit,
	output logic             reduced_power_bit,
	output logic [2:0]       kseg_zero_coherency,
	output logic [2:0]       config_mirror,
	output logic [7:0]       scratch_select_present,
	output logic             debug_mode_bit,
	output logic             load_store_normal_bit,
	output logic             fetch_bus_error_pending,
	output logic             data_bus_error_pending,
	output logic             imprecise_exception_inhibit,
	output logic             single_step_bit,
	output logic             timer_irq,
	output logic             bus_req,
	output logic [31:0]      bus_addr,
	output logic             boot_pending
);
	// ****************************************
	// Internal state
	// ****************************************
	logic        any_reset;              // Cold or soft reset
	logic [31:0] error_return_pc;        // Stored PC
	logic [1:0]  instruction_set_select; // Instruction set field
	logic [31:0] parity_error_info;      // Captured parity info
	logic        rd_store;               // Read targets word store
	epr_cop_if   cop ();                 // Store carrier

	assign any_reset = rst | soft_reset_input;

	// Decode a move to a given register and select
	function automatic logic hit(input logic [4:0] r, input logic [2:0] s,
	                             input logic [4:0] rr, input logic [2:0] ss);
		hit = (r == rr) && (s == ss);
	endfunction : hit

	// ****************************************
	// Status, config and debug reset values
	// ****************************************
	// Both resets act alike except the soft reset flag
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			boot_vector_bit   <= 1'b1;
			error_level_bit   <= 1'b1;
			tlb_shutdown_bit  <= 1'b0;
			nmi_status_bit    <= 1'b0;
			reduced_power_bit <= 1'b0;
			soft_reset_flag   <= ~rst;
		end else if (ce && nmi_exception) begin
			nmi_status_bit  <= 1'b1;
			error_level_bit <= 1'b1;
		end else if (ce && error_exception) begin
			error_level_bit <= 1'b1;
		end
	end

	// Config fields
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			kseg_zero_coherency    <= KSEG0_UNCACHED;
			config_mirror          <= static_config_in;
			scratch_select_present <= SCRATCH_PRESENT;
		end
	end

	// Debug fields
	always_ff @(posedge clk_sys) begin
		if (any_reset) begin
			debug_mode_bit              <= boot_into_debug_option;
			load_store_normal_bit       <= 1'b0;
			fetch_bus_error_pending     <= 1'b0;
			data_bus_error_pending      <= 1'b0;
			imprecise_exception_inhibit <= 1'b0;
			single_step_bit             <= 1'b0;
		end
	end

	// ****************************************
	// Parity error capture
	// ****************************************
	// Held except when a parity error is signalled
	always_ff @(posedge clk_sys) begin
		if (ce && parity_error) begin
			parity_error_info[PI_REF_BIT]     <= parity_ref_data;
			parity_error_info[PI_EXTRA_BIT]   <= parity_extra_data;
			parity_error_info[PI_ADDR_W-1:0]  <= parity_addr;
		end
	end

	// ****************************************
	// Error return PC
	// ****************************************
	// Hardware capture has priority over a software write
	always_ff @(posedge clk_sys) begin
		if (any_reset || (ce && (error_exception || nmi_exception))) begin
			error_return_pc <= fault_in_delay_slot ? branch_pc : fault_pc;
		end else if (ce && mtc0 && hit(cop_reg, cop_sel, REG_ERROR_PC, 3'h0)) begin
			error_return_pc        <= {cop_wdata[31:1], 1'b0};
			instruction_set_select <= {1'b0, cop_wdata[0]};
		end
	end

	// ****************************************
	// Timer interrupt
	// ****************************************
	// Set wins over the clear by a match write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			timer_irq <= 1'b0;
		end else if (ce) begin
			if (timer_irq_set) timer_irq <= 1'b1;
			else if (mtc0 && hit(cop_reg, cop_sel, REG_TIMER_MATCH, 3'h0))
				timer_irq <= 1'b0;
		end
	end

	// ****************************************
	// Store and read path
	// ****************************************
	assign cop.wr_save   = ce && mtc0 && hit(cop_reg, cop_sel, REG_SAVE_SCRATCH, SEL_DEBUG_SAVE);
	assign cop.wr_scr_lo = ce && mtc0 && hit(cop_reg, cop_sel, REG_SAVE_SCRATCH, SEL_SCRATCH_LO);
	assign cop.wr_scr_hi = ce && mtc0 && hit(cop_reg, cop_sel, REG_SAVE_SCRATCH, SEL_SCRATCH_HI);
	assign cop.wdata     = cop_wdata;
	assign cop.rsel      = cop_sel;

	epr_word_store u_store (
		.clk_sys (clk_sys),
		.ce      (ce),
		.bus     (cop.slave)
	);

	// Read mux; store words arrive one cycle later
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cop_rdata <= ZERO_WORD;
			rd_store  <= 1'b0;
		end else if (ce) begin
			rd_store <= mfc0 && (cop_reg == REG_SAVE_SCRATCH);
			if (mfc0 && cop_reg == REG_ERROR_PC)
				cop_rdata <= {error_return_pc[31:1], instruction_set_select[0]};
			else if (mfc0 && cop_reg == REG_PARITY_INFO)
				cop_rdata <= parity_error_info;
			else if (rd_store)
				cop_rdata <= cop.rdata;
			else if (mfc0)
				cop_rdata <= ZERO_WORD;
		end
	end

	// ****************************************
	// Fetch sequencer
	// ****************************************
	epr_fetch_seq u_fetch (
		.clk_sys                (clk_sys),
		.ce                     (ce),
		.any_reset              (any_reset),
		.boot_into_debug_option (boot_into_debug_option),
		.fetch_req              (fetch_req),
		.fetch_addr             (fetch_addr),
		.bus_ack                (bus_ack),
		.bus_req                (bus_req),
		.bus_addr               (bus_addr),
		.boot_pending           (boot_pending)
	);
endmodule : epr_top
`default_nettype wire

// ==== sim/epr_monitor.sv ====
// Checker of reset state, error PC folding, timer clear and boot fetch at the top ports.
// Assumes one clock domain; bound to every instance of the top module.
`timescale 1ns/1ps
`default_nettype none
module epr_monitor
	import epr_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        ce,
	input wire logic        rst,
	input wire logic        soft_reset_input,
	input wire logic        boot_into_debug_option,
	input wire logic        error_exception,
	input wire logic        nmi_exception,
	input wire logic        mtc0,
	input wire logic        mfc0,
	input wire logic [4:0]  cop_reg,
	input wire logic [2:0]  cop_sel,
	input wire logic [31:0] cop_wdata,
	input wire logic        timer_irq_set,
	input wire logic        bus_ack,
	input wire logic [31:0] cop_rdata,
	input wire logic        boot_vector_bit,
	input wire logic        soft_reset_flag,
	input wire logic        error_level_bit,
	input wire logic [2:0]  kseg_zero_coherency,
	input wire logic [7:0]  scratch_select_present,
	input wire logic        debug_mode_bit,
	input wire logic        timer_irq,
	input wire logic        bus_req,
	input wire logic [31:0] bus_addr,
	input wire logic        boot_pending
);
	// ****************************************
	// Properties
	// ****************************************
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Clean error PC move, no exception or soft reset beside it
	sequence s_epc(logic s);
		ce && s && cop_reg == REG_ERROR_PC && cop_sel == 3'h0 && !error_exception &&
			!nmi_exception && !soft_reset_input;
	endsequence
	a_cold_reset_state: assert property ($fell(rst) |->
		!soft_reset_flag && boot_vector_bit && error_level_bit) else $error("cold reset state");
	a_soft_reset_state: assert property (soft_reset_input |=>
		soft_reset_flag && boot_vector_bit && error_level_bit && !bus_req)
		else $error("soft reset state");
	a_reset_loads_fields: assert property (($fell(rst) || $past(soft_reset_input)) |->
		kseg_zero_coherency == KSEG0_UNCACHED && debug_mode_bit == $past(boot_into_debug_option))
		else $error("reset field values");
	a_boot_fetch_addr: assert property ((bus_req && boot_pending) |->
		bus_addr == BOOT_VECTOR) else $error("boot fetch address");
	a_boot_req_soon: assert property (($fell(rst) && boot_pending) |-> ##[0:3] bus_req)
		else $error("boot fetch not issued");
	a_ack_ends_boot: assert property ((bus_req && bus_ack && boot_pending && ce) |=>
		!bus_req && !boot_pending) else $error("boot fetch not closed");
	a_epc_read_fold: assert property (s_epc(mtc0) ##1 s_epc(mfc0 && !mtc0) |=>
		cop_rdata == $past(cop_wdata, 2)) else $error("error PC read back");
	a_timer_match_clear: assert property ((ce && mtc0 && cop_reg == REG_TIMER_MATCH &&
		cop_sel == 3'h0 && !timer_irq_set) |=> !timer_irq) else $error("timer not cleared");
	a_scratch_present: assert property (scratch_select_present == SCRATCH_PRESENT)
		else $error("scratch selects");
	// Main scenarios
	c_soft: cover property (soft_reset_input ##1 soft_reset_flag);
	c_epc: cover property (s_epc(mtc0) ##1 s_epc(mfc0));
	c_boot: cover property (bus_req && bus_ack);
endmodule : epr_monitor
bind epr_top epr_monitor epr_monitor_inst (.clk_sys, .ce, .rst, .soft_reset_input,
	.boot_into_debug_option, .error_exception, .nmi_exception, .mtc0, .mfc0, .cop_reg,
	.cop_sel, .cop_wdata, .timer_irq_set, .bus_ack, .cop_rdata, .boot_vector_bit,
	.soft_reset_flag, .error_level_bit, .kseg_zero_coherency, .scratch_select_present,
	.debug_mode_bit, .timer_irq, .bus_req, .bus_addr, .boot_pending);
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench of the error and reset state block.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
`default_nettype none
module tb
	import epr_pkg::*;
;
	typedef struct {int due; int kind; logic [31:0] val; logic [31:0] msk;} epr_note_t;
	logic        clk_sys = 1'h0, ce = 1'h1, rst = 1'h1, soft_reset_input = 1'h0;
	logic        boot_into_debug_option = 1'h0, parity_error = 1'h0, parity_ref_data = 1'h0;
	logic        parity_extra_data = 1'h0, error_exception = 1'h0, nmi_exception = 1'h0;
	logic        fault_in_delay_slot = 1'h0, mtc0 = 1'h0, mfc0 = 1'h0, timer_irq_set = 1'h0;
	logic        fetch_req = 1'h0, bus_ack = 1'h0;
	logic [2:0]  static_config_in = 3'h0, cop_sel = 3'h0, kseg_zero_coherency, config_mirror;
	logic [4:0]  cop_reg = 5'h00;
	logic [29:0] parity_addr = 30'h0;
	logic [31:0] fault_pc = 32'h0, branch_pc = 32'h0, cop_wdata = 32'h0, fetch_addr = 32'h0;
	logic [31:0] cop_rdata, bus_addr, d;
	logic [7:0]  scratch_select_present;
	logic        boot_vector_bit, tlb_shutdown_bit, soft_reset_flag, nmi_status_bit;
	logic        error_level_bit, reduced_power_bit, debug_mode_bit, load_store_normal_bit;
	logic        fetch_bus_error_pending, data_bus_error_pending, imprecise_exception_inhibit;
	logic        single_step_bit, timer_irq, bus_req, boot_pending;
	logic [15:0] seed = 16'hbd16;
	logic [31:0] v [3];
	logic [2:0]  sl [3] = '{SEL_DEBUG_SAVE, SEL_SCRATCH_LO, SEL_SCRATCH_HI};
	int          cyc = 0, bad_count = 0, tests_run = 0, i;
	epr_note_t   notes [$];
	// Status outputs packed, timer at bit 20, bus request at bit 0
	wire  [31:0] stat = {11'h000, timer_irq, boot_vector_bit, tlb_shutdown_bit, soft_reset_flag,
		nmi_status_bit, error_level_bit, reduced_power_bit, kseg_zero_coherency, config_mirror,
		debug_mode_bit, load_store_normal_bit, fetch_bus_error_pending, data_bus_error_pending,
		imprecise_exception_inhibit, single_step_bit, boot_pending, bus_req};
	epr_top epr_top_inst (.clk_sys, .ce, .rst, .soft_reset_input, .boot_into_debug_option,
		.static_config_in, .parity_error, .parity_ref_data, .parity_extra_data, .parity_addr,
		.error_exception, .nmi_exception, .fault_pc, .fault_in_delay_slot, .branch_pc, .mtc0,
		.mfc0, .cop_reg, .cop_sel, .cop_wdata, .timer_irq_set, .fetch_req, .fetch_addr, .bus_ack,
		.cop_rdata, .boot_vector_bit, .tlb_shutdown_bit, .soft_reset_flag, .nmi_status_bit,
		.error_level_bit, .reduced_power_bit, .kseg_zero_coherency, .config_mirror,
		.scratch_select_present, .debug_mode_bit, .load_store_normal_bit,
		.fetch_bus_error_pending, .data_bus_error_pending, .imprecise_exception_inhibit,
		.single_step_bit, .timer_irq, .bus_req, .bus_addr, .boot_pending);
	always #20 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;
	// ****************************************
	// Helpers
	// ****************************************
	task automatic step(); @(posedge clk_sys); #1; endtask : step
	function automatic logic [31:0] rnd();
		logic [15:0] lo;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		lo = seed;
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return {seed, lo};
	endfunction : rnd
	task automatic give_verdict();
		if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	task automatic note_exp(input int k, input int lat, input logic [31:0] e, input logic [31:0] m);
		notes.push_back('{cyc + lat, k, e, m});
	endtask : note_exp
	task automatic cmp(input logic [31:0] got, input epr_note_t n);
		tests_run++;
		if ((got & n.msk) !== (n.val & n.msk)) begin
			bad_count++;
			$display("[FAIL] %0t kind %0d got %h exp %h", $time, n.kind, got, n.val);
		end
	endtask : cmp
	task automatic cmp_rd(input epr_note_t n); cmp(cop_rdata, n); endtask : cmp_rd
	task automatic cmp_st(input epr_note_t n); cmp(stat, n); endtask : cmp_st
	task automatic cmp_bus(input epr_note_t n); cmp(bus_addr, n); endtask : cmp_bus
	// Every due note, oldest first, compared against settled outputs
	always @(negedge clk_sys) begin
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			case (notes[0].kind)
				0: cmp_rd(notes[0]);
				1: cmp_st(notes[0]);
				default: cmp_bus(notes[0]);
			endcase
			void'(notes.pop_front());
		end
	end
	task automatic wr(input logic [4:0] r, input logic [2:0] s, input logic [31:0] x);
		{mtc0, cop_reg, cop_sel, cop_wdata} = {1'h1, r, s, x};
		step();
		mtc0 = 1'h0;
	endtask : wr
	// Read with a spare cycle after, which keeps save reads two apart
	task automatic rd(input logic [4:0] r, input logic [2:0] s, input logic [31:0] e);
		{mfc0, cop_reg, cop_sel} = {1'h1, r, s};
		step();
		mfc0 = 1'h0;
		note_exp(0, int'(r == REG_SAVE_SCRATCH), e, 32'hffffffff);
		step();
	endtask : rd
	task automatic do_reset(input logic sft, input logic dbg);
		int n;
		d = rnd();
		{static_config_in, boot_into_debug_option} = {d[2:0], dbg};
		if (sft) soft_reset_input = 1'h1;
		else rst = 1'h1;
		repeat (sft ? 1 : 10) step();
		{rst, soft_reset_input} = 2'h0;
		note_exp(1, 0, {12'h000, 6'(sft << 3 | 6'h22), KSEG0_UNCACHED, d[2:0], dbg, 5'h00, ~dbg,
			1'h0}, 32'h000ffffe);
		if (!dbg) begin
			for (n = 0; n < 20 && bus_req !== 1'h1; n++) step();
			if (bus_req !== 1'h1) begin bad_count++; give_verdict(); end
			note_exp(2, 0, BOOT_VECTOR, 32'hffffffff);
			bus_ack = 1'h1;
			step();
			bus_ack = 1'h0;
			note_exp(1, 0, 32'h0, 32'h3);
		end
	endtask : do_reset
	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		do_reset(1'h0, 1'h0);
		for (i = 0; i < 4; i++) begin
			d = rnd();
			wr(REG_ERROR_PC, 3'h0, d);
			rd(REG_ERROR_PC, 3'h0, d);
		end
		// Clock enable low freezes the error PC against a write
		ce = 1'h0;
		wr(REG_ERROR_PC, 3'h0, {~d[31:1], d[0]});
		ce = 1'h1;
		rd(REG_ERROR_PC, 3'h0, d);
		for (i = 0; i < 4; i++) begin
			{fault_pc, branch_pc, fault_in_delay_slot} = {rnd(), rnd(), i[0]};
			{error_exception, nmi_exception} = {!i[1], i[1]};
			step();
			{error_exception, nmi_exception} = 2'h0;
			note_exp(1, 0, {15'h0000, i[1], 1'h1, 15'h0000}, 32'h00018000);
			d = i[0] ? branch_pc : fault_pc;
			rd(REG_ERROR_PC, 3'h0, {d[31:1], cop_wdata[0]});
		end
		for (i = 0; i < 2; i++) begin
			d = rnd();
			{parity_ref_data, parity_extra_data, parity_addr, parity_error} = {d, 1'h1};
			step();
			{parity_ref_data, parity_extra_data, parity_addr, parity_error} = {~d, 1'h0};
			rd(REG_PARITY_INFO, 3'h0, d);
			rd(REG_PARITY_INFO, 3'h0, d);
		end
		for (i = 0; i < 3; i++) begin
			v[i] = rnd();
			wr(REG_SAVE_SCRATCH, sl[i], v[i]);
			step();
		end
		wr(REG_SAVE_SCRATCH, SEL_RESERVED, rnd());
		rd(REG_SAVE_SCRATCH, SEL_RESERVED, ZERO_WORD);
		for (i = 0; i < 3; i++) rd(REG_SAVE_SCRATCH, sl[i], v[i]);
		rd(REG_SAVE_SCRATCH, 3'h4, ZERO_WORD);
		rd(5'h05, 3'h0, ZERO_WORD);
		timer_irq_set = 1'h1;
		step();
		timer_irq_set = 1'h0;
		note_exp(1, 0, 32'h00100000, 32'h00100000);
		wr(REG_TIMER_MATCH, 3'h0, rnd());
		note_exp(1, 0, 32'h0, 32'h00100000);
		step();
		timer_irq_set = 1'h1;
		wr(REG_TIMER_MATCH, 3'h0, rnd());
		timer_irq_set = 1'h0;
		note_exp(1, 0, 32'h00100000, 32'h00100000);
		do_reset(1'h1, 1'h0);
		do_reset(1'h1, 1'h1);
		do_reset(1'h0, 1'h0);
		repeat (2) step();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
